// ==== include/mtsr_pkg.sv ====
`default_nettype none
package mtsr_pkg;
	// Register offsets (register index on the management port)
	localparam logic [7:0] OFFS_BEMF     = 8'h03;
	localparam logic [7:0] OFFS_PEAK     = 8'h04;
	localparam logic [7:0] OFFS_POS_SUP  = 8'h05;
	localparam logic [7:0] OFFS_SPEED    = 8'h06;
	localparam logic [7:0] OFFS_ANALOG   = 8'h07;
	// Field widths and positions
	localparam int PEAK_W       = 11;
	localparam int ANALOG_W     = 10;
	localparam int BYTE_W       = 8;
	localparam int HI_LSB       = 8;
	// Reset value of every register
	localparam logic [15:0] RESET_VAL = 16'h0000;
	// Encoding constants that software uses to scale the fields, then the position field width
	localparam int BEMF_DIV     = 1090;
	localparam int PEAK_OFFSET  = 1023;
	localparam int PEAK_DIV     = 512;
	localparam int SUPPLY_FS_V  = 30;
	localparam int SUPPLY_DIV   = 255;
	localparam int ANALOG_DIV   = 1024;
	localparam int POS_W        = 8;

	// Measured values from the motor-control core
	typedef struct packed {
		logic [15:0]         bemf_constant_value;
		logic [PEAK_W-1:0]   peak_current_value;
		logic [POS_W-1:0]    initial_position_estimate;
		logic [POS_W-1:0]    position_advance_angle;
		logic [BYTE_W-1:0]   supply_level_value;
		logic [BYTE_W-1:0]   speed_command_value;
		logic [BYTE_W-1:0]   buffered_speed_command;
		logic [ANALOG_W-1:0] analog_speed_sample;
	} mtsr_meas_type;

	// Register access request from the serial management port
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} mtsr_req_type;

	// Whole module state
	typedef struct packed {
		logic [15:0] bemf_q;
		logic [15:0] peak_q;
		logic [15:0] pos_sup_q;
		logic [15:0] speed_q;
		logic [15:0] analog_q;
		logic [15:0] rdata_q;
		logic        rvalid_q;
		logic        hit_q;
	} mtsr_state_type;
endpackage
`default_nettype wire

// ==== src/mtsr_regs.sv ====
`default_nettype none
module mtsr_regs
(
	input  wire logic                   CLOCK_IN,
	input  wire logic                   RESET_IN,
	input  wire mtsr_pkg::mtsr_meas_type MEAS_IN,
	input  wire mtsr_pkg::mtsr_req_type  REQ_IN,
	output logic [15:0]                 RDATA_OUT,
	output logic                        RVALID_OUT,
	output logic                        HIT_OUT
);
	mtsr_pkg::mtsr_state_type s_q;
	mtsr_pkg::mtsr_state_type s_d;
	logic [7:0] pos_sum;

	// Reported position is estimate plus advance, modulo one turn
	assign pos_sum = 8'(MEAS_IN.initial_position_estimate
		+ MEAS_IN.position_advance_angle);

	// Offset decode shared by the read path and its checks
	function automatic logic is_mapped(input logic [7:0] ad);
		logic hit;
		hit = 1'b0;
		if (ad == mtsr_pkg::OFFS_BEMF)
			hit = 1'b1;
		else if (ad == mtsr_pkg::OFFS_PEAK)
			hit = 1'b1;
		else if (ad == mtsr_pkg::OFFS_POS_SUP)
			hit = 1'b1;
		else if (ad == mtsr_pkg::OFFS_SPEED)
			hit = 1'b1;
		else if (ad == mtsr_pkg::OFFS_ANALOG)
			hit = 1'b1;
		return hit;
	endfunction

	// Next state: snapshot values every cycle, answer reads
	always_comb
	begin
		s_d = s_q;
		s_d.bemf_q    = MEAS_IN.bemf_constant_value;
		s_d.peak_q    = {5'h00, MEAS_IN.peak_current_value};
		s_d.pos_sup_q = {pos_sum, MEAS_IN.supply_level_value};
		s_d.speed_q   = {MEAS_IN.speed_command_value,
			MEAS_IN.buffered_speed_command};
		s_d.analog_q  = {6'h00, MEAS_IN.analog_speed_sample};
		s_d.rvalid_q  = REQ_IN.rd;
		s_d.hit_q     = 1'b0;
		s_d.rdata_q   = 16'h0000;
		// Read decode; writes fall through untouched
		if (REQ_IN.rd)
		begin
			s_d.hit_q = is_mapped(REQ_IN.addr);
			if (REQ_IN.addr == mtsr_pkg::OFFS_BEMF)
				s_d.rdata_q = s_q.bemf_q;
			else if (REQ_IN.addr == mtsr_pkg::OFFS_PEAK)
				s_d.rdata_q = s_q.peak_q;
			else if (REQ_IN.addr == mtsr_pkg::OFFS_POS_SUP)
				s_d.rdata_q = s_q.pos_sup_q;
			else if (REQ_IN.addr == mtsr_pkg::OFFS_SPEED)
				s_d.rdata_q = s_q.speed_q;
			else if (REQ_IN.addr == mtsr_pkg::OFFS_ANALOG)
				s_d.rdata_q = s_q.analog_q;
		end
	end

	// State register; REQ_IN.wr never reaches contents
	always_ff @(posedge CLOCK_IN)
	begin
		if (RESET_IN)
		begin
			s_q.bemf_q    <= mtsr_pkg::RESET_VAL;
			s_q.peak_q    <= mtsr_pkg::RESET_VAL;
			s_q.pos_sup_q <= mtsr_pkg::RESET_VAL;
			s_q.speed_q   <= mtsr_pkg::RESET_VAL;
			s_q.analog_q  <= mtsr_pkg::RESET_VAL;
			s_q.rdata_q   <= 16'h0000;
			s_q.rvalid_q  <= 1'b0;
			s_q.hit_q     <= 1'b0;
		end
		else
			s_q <= s_d;
	end

	assign RDATA_OUT  = s_q.rdata_q;
	assign RVALID_OUT = s_q.rvalid_q;
	assign HIT_OUT    = s_q.hit_q;

	// Read request at one offset, snapshot already valid
	sequence s_read_at(logic [7:0] ad);
		REQ_IN.rd && REQ_IN.addr == ad && !$past(RESET_IN);
	endsequence

	// Answer that stands for one cycle as a mapped hit
	sequence s_hit_answer;
		RVALID_OUT && HIT_OUT;
	endsequence

	// Reserved upper bits of peak current read zero
	a_peak_reserved: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_read_at(mtsr_pkg::OFFS_PEAK) |=> s_hit_answer ##0 (RDATA_OUT[15:11] == 5'h00))
		else $error("peak reserved bits set");

	// Peak current field read back unchanged
	a_peak_value: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_read_at(mtsr_pkg::OFFS_PEAK) |=> RDATA_OUT[10:0] == $past(MEAS_IN.peak_current_value, 2))
		else $error("peak value wrong");

	// Analog reserved bits read zero
	a_analog_reserved: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_read_at(mtsr_pkg::OFFS_ANALOG) |=> s_hit_answer ##0 (RDATA_OUT[15:10] == 6'h00))
		else $error("analog reserved bits set");

	// Analog sample read back unchanged
	a_analog_value: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_read_at(mtsr_pkg::OFFS_ANALOG) |=> RDATA_OUT[9:0] == $past(MEAS_IN.analog_speed_sample, 2))
		else $error("analog value wrong");

	// Back-EMF read returns value captured two edges earlier
	a_bemf_read: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_read_at(mtsr_pkg::OFFS_BEMF) |=> s_hit_answer
		##0 (RDATA_OUT == $past(MEAS_IN.bemf_constant_value, 2)))
		else $error("bemf read mismatch");

	// Position byte read back as estimate plus advance
	a_pos_read: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_read_at(mtsr_pkg::OFFS_POS_SUP) |=> RDATA_OUT[15:8]
		== 8'($past(MEAS_IN.initial_position_estimate, 2) + $past(MEAS_IN.position_advance_angle, 2)))
		else $error("position read wrong");

	// Supply byte read back in low half
	a_supply_read: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_read_at(mtsr_pkg::OFFS_POS_SUP) |=> RDATA_OUT[7:0] == $past(MEAS_IN.supply_level_value, 2))
		else $error("supply read wrong");

	// Speed bytes read back raw high, buffered low
	a_speed_read: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		s_read_at(mtsr_pkg::OFFS_SPEED) |=> RDATA_OUT == {$past(MEAS_IN.speed_command_value, 2),
		$past(MEAS_IN.buffered_speed_command, 2)})
		else $error("speed read wrong");

	// Position field carries estimate plus advance
	a_pos_adv: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!$past(RESET_IN) |-> s_q.pos_sup_q[15:8] == 8'($past(MEAS_IN.initial_position_estimate)
		+ $past(MEAS_IN.position_advance_angle))) else $error("position sum wrong");

	// Supply in low byte of combined register
	a_supply_low: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!$past(RESET_IN) |-> s_q.pos_sup_q[7:0] == $past(MEAS_IN.supply_level_value))
		else $error("supply byte wrong");

	// Raw and buffered speed bytes in order
	a_speed_order: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!$past(RESET_IN) |-> s_q.speed_q == {$past(MEAS_IN.speed_command_value),
		$past(MEAS_IN.buffered_speed_command)}) else $error("speed order wrong");

	// Back-EMF snapshot follows the measurement
	a_bemf_snap: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!$past(RESET_IN) |-> s_q.bemf_q == $past(MEAS_IN.bemf_constant_value))
		else $error("bemf snapshot wrong");

	// Peak snapshot follows the measurement
	a_peak_snap: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!$past(RESET_IN) |-> s_q.peak_q == {5'h00, $past(MEAS_IN.peak_current_value)})
		else $error("peak snapshot wrong");

	// Analog snapshot follows the measurement
	a_analog_snap: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!$past(RESET_IN) |-> s_q.analog_q == {6'h00, $past(MEAS_IN.analog_speed_sample)})
		else $error("analog snapshot wrong");

	// Unmapped read answers zero without hit
	a_unmapped_zero: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_IN.rd && (REQ_IN.addr < mtsr_pkg::OFFS_BEMF
		|| REQ_IN.addr > mtsr_pkg::OFFS_ANALOG)
		|=> RVALID_OUT && !HIT_OUT && RDATA_OUT == 16'h0000)
		else $error("unmapped read not zero");

	// Mapped read always answers as a hit
	a_mapped_hit: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_IN.rd && is_mapped(REQ_IN.addr) |=> s_hit_answer)
		else $error("mapped read missed");

	// Every read gets its valid pulse one cycle later
	a_read_pulse: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_IN.rd |=> RVALID_OUT)
		else $error("read not answered");

	// No read, no answer: outputs fall back to zero
	a_idle_quiet: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		!REQ_IN.rd |=> !RVALID_OUT && !HIT_OUT && RDATA_OUT == 16'h0000)
		else $error("answer without read");

	// Hit only stands with valid
	a_hit_valid: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		HIT_OUT |-> RVALID_OUT)
		else $error("hit without valid");

	// A write alone leaves read valid low and peak field follows input
	a_write_ignored: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_IN.wr && !REQ_IN.rd |=> !RVALID_OUT
		&& s_q.peak_q[10:0] == $past(MEAS_IN.peak_current_value))
		else $error("write had effect");

	// A write alone puts nothing on the read port
	a_write_silent: assert property (@(posedge CLOCK_IN) disable iff (RESET_IN)
		REQ_IN.wr && !REQ_IN.rd |=> !HIT_OUT && RDATA_OUT == 16'h0000)
		else $error("write drove read port");

	// Reset clears the read port at the next edge
	a_reset_clear: assert property (@(posedge CLOCK_IN)
		RESET_IN |=> !RVALID_OUT && !HIT_OUT && RDATA_OUT == 16'h0000)
		else $error("reset did not clear");
endmodule
`default_nettype wire

// ==== sim/mtsr_host.sv ====
`default_nettype none
module mtsr_host
(
	input  wire logic             clock_in,
	input  wire logic [15:0]      rdata_in,
	input  wire logic             rvalid_in,
	input  wire logic             hit_in,
	output var mtsr_pkg::mtsr_req_type req_out
);
	timeunit 1ns;
	timeprecision 1ps;
	initial req_out = '0;
	// One access: strobe for one cycle, answer taken in the next
	task automatic access(input logic wr, input logic [7:0] addr, input logic [15:0] wdata,
		output logic [17:0] seen);
		@(posedge clock_in);
		#1;
		req_out = {~wr, wr, addr, wdata};
		@(posedge clock_in);
		#1;
		req_out = '0;
		seen = {rvalid_in, hit_in, rdata_in};
	endtask
endmodule
`default_nettype wire

// ==== sim/motor_telemetry_status_regs_tb_top.sv ====
`default_nettype none
module motor_telemetry_status_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                    clock = 1'b0;
	logic                    reset = 1'b1;
	mtsr_pkg::mtsr_meas_type meas = '0;
	mtsr_pkg::mtsr_req_type  req;
	logic [15:0]             rdata;
	logic                    rvalid;
	logic                    hit;
	logic [17:0]             seen;
	logic [7:0]              a;
	int                      n_mismatch = 0;
	int                      samples_checked = 0;
	int                      cycles = 0;
	always #2.5 clock = ~clock;
	mtsr_regs u_dut (.CLOCK_IN(clock), .RESET_IN(reset), .MEAS_IN(meas), .REQ_IN(req),
		.RDATA_OUT(rdata), .RVALID_OUT(rvalid), .HIT_OUT(hit));
	mtsr_host u_host (.clock_in(clock), .rdata_in(rdata), .rvalid_in(rvalid), .hit_in(hit),
		.req_out(req));
	// Expected hit flag and word for one offset
	function automatic logic [16:0] expect_word(input logic [7:0] ad,
		input mtsr_pkg::mtsr_meas_type m);
		case (ad)
			mtsr_pkg::OFFS_BEMF: return {1'b1, m.bemf_constant_value};
			mtsr_pkg::OFFS_PEAK: return {1'b1, 5'h00, m.peak_current_value};
			mtsr_pkg::OFFS_POS_SUP: return {1'b1,
				m.initial_position_estimate + m.position_advance_angle, m.supply_level_value};
			mtsr_pkg::OFFS_SPEED: return {1'b1, m.speed_command_value, m.buffered_speed_command};
			mtsr_pkg::OFFS_ANALOG: return {1'b1, 6'h00, m.analog_speed_sample};
			default: return 17'h00000;
		endcase
	endfunction
	// Compare and count
	task automatic check(input logic [17:0] got, input logic [17:0] want);
		samples_checked++;
		if (got !== want)
		begin
			n_mismatch++;
			$display("wrong value at %0t: saw %h want %h", $time, got, want);
		end
	endtask
	// Closing report
	task automatic stop_test();
		$display("mismatches %0d, checks %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Hang guard
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			n_mismatch++;
			stop_test();
		end
	end
	// Reset, then random values with a wrap corner first
	initial
	begin
		void'($urandom(32'h0C5A2895));
		repeat (10) @(posedge clock);
		#1;
		check({rvalid, hit, rdata}, 18'h00000);
		reset = 1'b0;
		for (int i = 0; i < 60; i++)
		begin
			meas = $bits(meas)'({$urandom, $urandom, $urandom});
			if (i == 0)
			begin
				meas.initial_position_estimate = 8'hFF;
				meas.position_advance_angle = 8'h03;
				meas.peak_current_value = 11'h3FF;
				meas.speed_command_value = 8'hFF;
			end
			u_host.access(1'b1, 8'($urandom_range(3, 7)), 16'($urandom), seen);
			check(seen, 18'h00000);
			for (int k = 2; k <= 8; k++)
			begin
				a = (k == 8) ? 8'($urandom_range(8, 255)) : 8'(k);
				u_host.access(1'b0, a, 16'($urandom), seen);
				check(seen, {1'b1, expect_word(a, meas)});
			end
		end
		stop_test();
	end
endmodule
`default_nettype wire
